// ===== include/arsc_pkg.sv
// Constants, field layouts and types of the converter read sequencer control.
// Assumes a 10 MHz MCLK and a register port driven by the serial control block.
// Behaviour
// - Converter powered up only while conv_enable set.
// - Writing conv_seq_start requests a general sequence.
// - Continuous repeats general sequences; else one per start.
// - Pending touch start served before general start.
// - General hold pauses sequencer; host holds while reading.
// - General sequence runs slot 0 to last slot.
// - Bit 8 selects manual LED control.
// - Touch path powered only while touch_enable set.
// - Writing touch_seq_start requests a touch sequence.
// - Touch continuous repeats; else one per start.
// - Touch hold pauses sequencer while host reads.
// - Touch sequence uses own last slot index.
// - Bit 20 enables pen detect; host clears touch_enable.
// - Pre delay before first general reading.
// - Inter delay between general readings in a sequence.
// - General post delay only between continuous wraps.
// - Four-bit channel select per result slot 0-5.
// - All control fields reset to zero.
// - Each result stored as 10 bits in slot field.
// - Touch action codes: discharge, X, Y, contact.
package arsc_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [5:0]  ADDR_CTRL    = 6'h2b;
  localparam logic [5:0]  ADDR_DELAY   = 6'h2c;
  localparam logic [5:0]  ADDR_SEL     = 6'h2d;
  localparam logic [5:0]  ADDR_TACT    = 6'h2e;
  localparam logic [5:0]  ADDR_RES01   = 6'h2f;
  localparam logic [5:0]  ADDR_RES23   = 6'h30;
  localparam logic [5:0]  ADDR_RES45   = 6'h31;
  localparam logic [23:0] REG_RESET    = 24'h000000;
  localparam int          TACT_POS     = 8;
  localparam int          RES_W        = 10;
  localparam int          SLOTS        = 8;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int DELAY_UNIT_NS = 10000;
  localparam int UNIT_CYCLES   = (DELAY_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DCNT_W        = 11;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic [2:0] spare_hi;
    logic       pen_detect_enable;
    logic       spare_19;
    logic [2:0] touch_seq_last_slot;
    logic       touch_seq_hold;
    logic       touch_seq_continuous;
    logic       touch_seq_start;
    logic       touch_enable;
    logic [2:0] spare_mid;
    logic       manual_led_control;
    logic       spare_7;
    logic [2:0] conv_seq_last_slot;
    logic       conv_seq_hold;
    logic       conv_seq_continuous;
    logic       conv_seq_start;
    logic       conv_enable;
  } arsc_ctrl_t;

  typedef struct packed {
    logic [3:0] touch_post_delay;
    logic [3:0] touch_inter_delay;
    logic [3:0] touch_pre_delay;
    logic [3:0] conv_post_delay;
    logic [3:0] conv_inter_delay;
    logic [3:0] conv_pre_delay;
  } arsc_delay_t;

  typedef enum logic [1:0] {
    TA_DISCHARGE = 2'h0,
    TA_READ_X    = 2'h1,
    TA_READ_Y    = 2'h2,
    TA_CONTACT   = 2'h3
  } arsc_touch_action_t;

  typedef struct packed {
    logic               touch;
    logic [3:0]         channel;
    arsc_touch_action_t action;
  } arsc_conv_req_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_DELAY = 4'h2,
    ST_ISSUE = 4'h4,
    ST_BUSY  = 4'h8
  } arsc_state_t;

endpackage

// ===== hdl/arsc_sequencer_control.sv
// Converter read sequencer control: registers, delays and slot walk.
// Assumes register port and converter handshake both run on MCLK.
`timescale 1ns/1ps
module arsc_sequencer_control
  import arsc_pkg::*;
(
  // Clock and reset
  input  wire logic            MCLK,
  input  wire logic            RST,
  // Register port from serial control block
  input  wire logic [5:0]      REG_ADDR,
  input  wire logic [23:0]     REG_WDATA,
  input  wire logic            REG_WR,
  input  wire logic            REG_RD,
  output logic      [23:0]     REG_RDATA,
  output logic                 REG_RVALID,
  // Converter handshake
  output logic                 CONV_REQ,
  output arsc_conv_req_t       CONV_REQ_INFO,
  input  wire logic            CONV_DONE,
  input  wire logic [RES_W-1:0] CONV_RESULT,
  // Power and mode levels
  output logic                 CONV_POWER_UP,
  output logic                 TOUCH_POWER_UP,
  output logic                 PEN_DETECT_EN,
  output logic                 MANUAL_LED,
  output logic                 SEQ_BUSY,
  output logic                 SEQ_TOUCH
);

  // ****************************************
  // Declarations
  // ****************************************
  arsc_ctrl_t          ctrl_r;
  arsc_delay_t         dly_r;
  logic [23:0]         sel_r;
  logic [23:0]         tact_r;
  logic [RES_W-1:0]    result_r [SLOTS];
  arsc_state_t         state_r;
  logic                touch_r;
  logic [2:0]          slot_r;
  logic [DCNT_W-1:0]   cnt_r;
  logic [RES_W-1:0]    pend_r;
  logic                pend_v_r;
  logic                hold;
  logic                run_en;
  logic                abort;
  logic                commit;
  logic                last;
  logic                seq_end;
  logic                go_touch;
  logic                go_conv;
  logic                pick_t;
  logic                pick_c;
  logic                wrap;
  logic [3:0]          inter_d;
  logic [3:0]          post_d;

  // Cycles loaded for a delay of u units, counted down to zero
  function automatic logic [DCNT_W-1:0] dly_load(input logic [3:0] u);
    dly_load = DCNT_W'(32'(u) * UNIT_CYCLES - 1);
  endfunction

  // ****************************************
  // Register file
  // ****************************************

  // Control register; a write in the clearing cycle wins over the clear
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ctrl_r <= arsc_ctrl_t'(REG_RESET);
    end else if (REG_WR && REG_ADDR == ADDR_CTRL) begin
      ctrl_r <= arsc_ctrl_t'(REG_WDATA);
    end else begin
      if (pick_t) begin
        ctrl_r.touch_seq_start <= 1'b0;
      end
      if (pick_c) begin
        ctrl_r.conv_seq_start <= 1'b0;
      end
    end
  end

  // Delay, channel select and touch action registers
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      dly_r  <= arsc_delay_t'(REG_RESET);
      sel_r  <= REG_RESET;
      tact_r <= REG_RESET;
    end else if (REG_WR) begin
      if (REG_ADDR == ADDR_DELAY) begin
        dly_r <= arsc_delay_t'(REG_WDATA);
      end else if (REG_ADDR == ADDR_SEL) begin
        sel_r <= REG_WDATA;
      end else if (REG_ADDR == ADDR_TACT) begin
        tact_r <= REG_WDATA;
      end
    end
  end

  // Read port; unmapped addresses read zero
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      REG_RDATA  <= REG_RESET;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_RD;
      if (!REG_RD) begin
        REG_RDATA <= REG_RDATA;
      end else if (REG_ADDR == ADDR_CTRL) begin
        REG_RDATA <= 24'(ctrl_r);
      end else if (REG_ADDR == ADDR_DELAY) begin
        REG_RDATA <= 24'(dly_r);
      end else if (REG_ADDR == ADDR_SEL) begin
        REG_RDATA <= sel_r;
      end else if (REG_ADDR == ADDR_TACT) begin
        REG_RDATA <= tact_r;
      end else if (REG_ADDR == ADDR_RES01) begin
        REG_RDATA <= {result_r[1], 2'h0, result_r[0], 2'h0};
      end else if (REG_ADDR == ADDR_RES23) begin
        REG_RDATA <= {result_r[3], 2'h0, result_r[2], 2'h0};
      end else if (REG_ADDR == ADDR_RES45) begin
        REG_RDATA <= {result_r[5], 2'h0, result_r[4], 2'h0};
      end else begin
        REG_RDATA <= REG_RESET;
      end
    end
  end

  // ****************************************
  // Sequencer decisions
  // ****************************************

  // Which sequence runs next and when the running one ends
  always_comb begin
    hold     = ctrl_r.conv_seq_hold | ctrl_r.touch_seq_hold;
    run_en   = touch_r ? ctrl_r.touch_enable : ctrl_r.conv_enable;
    abort    = (state_r != ST_IDLE) && !run_en;
    commit   = (state_r == ST_BUSY) && pend_v_r && !hold && !abort;
    last     = slot_r == (touch_r ? ctrl_r.touch_seq_last_slot : ctrl_r.conv_seq_last_slot);
    seq_end  = commit && last;
    go_touch = ctrl_r.touch_seq_start && ctrl_r.touch_enable;
    go_conv  = ctrl_r.conv_seq_start && ctrl_r.conv_enable;
    // Touch start takes precedence, also at the end of a general sequence
    pick_t   = !hold && go_touch && ((state_r == ST_IDLE) || (seq_end && !touch_r));
    pick_c   = !hold && go_conv && !go_touch && (state_r == ST_IDLE);
    wrap     = seq_end && !pick_t &&
               (touch_r ? ctrl_r.touch_seq_continuous : ctrl_r.conv_seq_continuous);
    inter_d  = touch_r ? dly_r.touch_inter_delay : dly_r.conv_inter_delay;
    post_d   = touch_r ? dly_r.touch_post_delay : dly_r.conv_post_delay;
  end

  // ****************************************
  // Sequencer state
  // ****************************************

  // Slot walk with delays; a zero delay goes straight to the request
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      state_r <= ST_IDLE;
      touch_r <= 1'b0;
      slot_r  <= 3'h0;
      cnt_r   <= '0;
    end else if (abort) begin
      state_r <= ST_IDLE;
    end else if (pick_t) begin
      touch_r <= 1'b1;
      slot_r  <= 3'h0;
      cnt_r   <= dly_load(dly_r.touch_pre_delay);
      state_r <= (dly_r.touch_pre_delay == 4'h0) ? ST_ISSUE : ST_DELAY;
    end else if (pick_c) begin
      touch_r <= 1'b0;
      slot_r  <= 3'h0;
      cnt_r   <= dly_load(dly_r.conv_pre_delay);
      state_r <= (dly_r.conv_pre_delay == 4'h0) ? ST_ISSUE : ST_DELAY;
    end else if (!hold) begin
      case (state_r)
        ST_DELAY: begin
          if (cnt_r == '0) begin
            state_r <= ST_ISSUE;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        ST_ISSUE: begin
          state_r <= ST_BUSY;
        end
        ST_BUSY: begin
          if (commit && !last) begin
            slot_r  <= slot_r + 3'h1;
            cnt_r   <= dly_load(inter_d);
            state_r <= (inter_d == 4'h0) ? ST_ISSUE : ST_DELAY;
          end else if (wrap) begin
            slot_r  <= 3'h0;
            cnt_r   <= dly_load(post_d);
            state_r <= (post_d == 4'h0) ? ST_ISSUE : ST_DELAY;
          end else if (seq_end) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= state_r;
        end
      endcase
    end
  end

  // Result waiting to be stored; held back while a hold is set
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      pend_r   <= '0;
      pend_v_r <= 1'b0;
    end else if (CONV_DONE && state_r == ST_BUSY) begin
      pend_r   <= CONV_RESULT;
      pend_v_r <= 1'b1;
    end else if (commit || abort) begin
      pend_v_r <= 1'b0;
    end
  end

  // Result slots
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < SLOTS; i++) begin
        result_r[i] <= '0;
      end
    end else if (commit) begin
      result_r[slot_r] <= pend_r;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************

  // Conversion request pulse with slot channel and touch action
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      CONV_REQ      <= 1'b0;
      CONV_REQ_INFO <= '0;
    end else begin
      CONV_REQ <= (state_r == ST_ISSUE) && !hold && !abort;
      if (state_r == ST_ISSUE) begin
        CONV_REQ_INFO.touch   <= touch_r;
        CONV_REQ_INFO.channel <= (slot_r < 3'h6) ? sel_r[4*slot_r +: 4] : tact_r[4*(slot_r-3'h6) +: 4];
        CONV_REQ_INFO.action  <= arsc_touch_action_t'(tact_r[TACT_POS + 2*slot_r +: 2]);
      end
    end
  end

  // Power and mode levels
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      CONV_POWER_UP  <= 1'b0;
      TOUCH_POWER_UP <= 1'b0;
      PEN_DETECT_EN  <= 1'b0;
      MANUAL_LED     <= 1'b0;
      SEQ_BUSY       <= 1'b0;
      SEQ_TOUCH      <= 1'b0;
    end else begin
      CONV_POWER_UP  <= ctrl_r.conv_enable;
      TOUCH_POWER_UP <= ctrl_r.touch_enable;
      PEN_DETECT_EN  <= ctrl_r.pen_detect_enable;
      MANUAL_LED     <= ctrl_r.manual_led_control;
      SEQ_BUSY       <= state_r != ST_IDLE;
      SEQ_TOUCH      <= touch_r;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  sequence s_issue;
    (state_r == ST_ISSUE) && !hold && !abort;
  endsequence
  sequence s_req;
    CONV_REQ ##1 !CONV_REQ;
  endsequence

  property p_gen_req_enabled;
    (CONV_REQ && !CONV_REQ_INFO.touch) |-> $past(ctrl_r.conv_enable, 2);
  endproperty
  a_gen_req_enabled: assert property (p_gen_req_enabled) else $error("general request while disabled");

  property p_issue_pulse;
    s_issue |=> s_req;
  endproperty
  a_issue_pulse: assert property (p_issue_pulse) else $error("request pulse missing");

  property p_gen_start;
    (state_r == ST_IDLE && go_conv && !go_touch && !hold && !(REG_WR && REG_ADDR == ADDR_CTRL)) |=>
      (state_r != ST_IDLE) && !touch_r && !ctrl_r.conv_seq_start;
  endproperty
  a_gen_start: assert property (p_gen_start) else $error("general start not taken");

  property p_touch_first;
    (state_r == ST_IDLE && go_touch && go_conv && !hold && !(REG_WR && REG_ADDR == ADDR_CTRL)) |=>
      touch_r && ctrl_r.conv_seq_start;
  endproperty
  a_touch_first: assert property (p_touch_first) else $error("touch start not first");

  property p_hold_freezes;
    (hold && !abort && !(REG_WR && REG_ADDR == ADDR_CTRL)) |=> $stable(state_r) && $stable(slot_r) && $stable(cnt_r);
  endproperty
  a_hold_freezes: assert property (p_hold_freezes) else $error("sequencer moved while held");

  property p_slot_step;
    (commit && !last) |=> slot_r == $past(slot_r) + 3'h1;
  endproperty
  a_slot_step: assert property (p_slot_step) else $error("slot did not advance by one");

  property p_one_shot_ends;
    (seq_end && !wrap && !pick_t) |=> state_r == ST_IDLE;
  endproperty
  a_one_shot_ends: assert property (p_one_shot_ends) else $error("one-shot sequence did not stop");

  property p_inter_load;
    (commit && !last && inter_d != 4'h0) |=> (state_r == ST_DELAY) && (cnt_r == dly_load($past(inter_d)));
  endproperty
  a_inter_load: assert property (p_inter_load) else $error("inter delay not loaded");

  property p_delay_expire;
    (state_r == ST_DELAY && cnt_r == '0 && !hold && !abort && !pick_t && !pick_c) |=> s_issue or (state_r == ST_ISSUE);
  endproperty
  a_delay_expire: assert property (p_delay_expire) else $error("delay did not end at zero");

  property p_result_store;
    commit |=> result_r[$past(slot_r)] == $past(pend_r);
  endproperty
  a_result_store: assert property (p_result_store) else $error("result not stored in slot");

  property p_wrap_post;
    (wrap && post_d != 4'h0) |=> (state_r == ST_DELAY) && (slot_r == 3'h0) &&
      (cnt_r == dly_load($past(post_d)));
  endproperty
  a_wrap_post: assert property (p_wrap_post) else $error("post delay not loaded on wrap");

  property p_touch_pre;
    (pick_t && dly_r.touch_pre_delay != 4'h0) |=> touch_r && (state_r == ST_DELAY) &&
      (cnt_r == dly_load($past(dly_r.touch_pre_delay)));
  endproperty
  a_touch_pre: assert property (p_touch_pre) else $error("touch pre delay not loaded");

endmodule

// ===== tb/arsc_conv_model.sv
// Behavioural converter that answers sequencer requests.
// Assumes one request outstanding at a time, all on the sequencer clock.
`timescale 1ns/1ps
module arsc_conv_model
  import arsc_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Request side
  input  wire logic             req,
  input  arsc_conv_req_t        info,
  input  wire logic [3:0]       lat,
  // Answer side
  output logic                  done,
  output logic      [RES_W-1:0] result
);
  logic [3:0]       cnt_r;
  logic [RES_W-1:0] val_r;

  // Count out the latency, then pulse done; result is junk outside the pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r  <= 4'h0;
      val_r  <= '0;
      done   <= 1'b0;
      result <= '0;
    end else begin
      done <= 1'b0;
      if (cnt_r == 4'h1) begin
        done   <= 1'b1;
        result <= val_r;
      end else begin
        result <= ~result;  // Stale value inverted each cycle, so it equals the last result every other cycle
      end
      if (req) begin
        cnt_r <= lat;
        val_r <= {info.channel, ~info.channel, 2'h1};
      end else if (cnt_r != 4'h0) begin
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the converter read sequencer control.
// Assumes the design package and the converter model are compiled first.
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch %0t got %0h exp %0h", $time, (g), (e)); end end
module testbench;
  import arsc_pkg::*;
  logic             MCLK = 1'b0;
  logic             RST = 1'b1;
  logic [5:0]       REG_ADDR = 6'h00;
  logic [23:0]      REG_WDATA = 24'h000000;
  logic             REG_WR = 1'b0;
  logic             REG_RD = 1'b0;
  logic [23:0]      REG_RDATA;
  logic             REG_RVALID, CONV_REQ, CONV_DONE, CONV_POWER_UP, TOUCH_POWER_UP;
  logic             PEN_DETECT_EN, MANUAL_LED, SEQ_BUSY, SEQ_TOUCH;
  arsc_conv_req_t   CONV_REQ_INFO;
  logic [RES_W-1:0] CONV_RESULT;
  logic [3:0]       lat = 4'h3;
  logic [15:0]      lf = 16'hdc04;
  int               n_errors = 0;
  int               cmp_count = 0;
  arsc_conv_req_t   rq[$];
  time              tq[$];
  time              t_wr;

  // ****************************************
  // Clock, design and converter
  // ****************************************
  always #50 MCLK = ~MCLK;

  arsc_sequencer_control dut (
    .MCLK(MCLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .CONV_REQ(CONV_REQ),
    .CONV_REQ_INFO(CONV_REQ_INFO), .CONV_DONE(CONV_DONE), .CONV_RESULT(CONV_RESULT),
    .CONV_POWER_UP(CONV_POWER_UP), .TOUCH_POWER_UP(TOUCH_POWER_UP), .PEN_DETECT_EN(PEN_DETECT_EN),
    .MANUAL_LED(MANUAL_LED), .SEQ_BUSY(SEQ_BUSY), .SEQ_TOUCH(SEQ_TOUCH)
  );

  arsc_conv_model conv (
    .clk(MCLK), .rst(RST), .req(CONV_REQ), .info(CONV_REQ_INFO), .lat(lat),
    .done(CONV_DONE), .result(CONV_RESULT)
  );

  // Log every conversion request with its time
  always @(posedge MCLK) begin
    if (CONV_REQ === 1'b1) begin
      rq.push_back(CONV_REQ_INFO);
      tq.push_back($time);
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  // Two LFSR steps make one 24-bit random word
  function automatic logic [23:0] rnd24();
    logic [15:0] a;
    a = lfsr_next(lf);
    lf = lfsr_next(a);
    return {a[7:0], lf};
  endfunction

  // Value the converter returns for a channel
  function automatic logic [RES_W-1:0] exp_res(input logic [3:0] c);
    return {c, ~c, 2'h1};
  endfunction

  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    @(posedge MCLK);
    REG_ADDR  <= a;
    REG_WDATA <= d;
    REG_WR    <= 1'b1;
    @(posedge MCLK);
    REG_WR <= 1'b0;
    t_wr = $time;
  endtask

  task automatic rd(input logic [5:0] a, output logic [23:0] d);
    @(posedge MCLK);
    REG_ADDR <= a;
    REG_RD   <= 1'b1;
    @(posedge MCLK);
    REG_RD <= 1'b0;
    #1;
    `CHK(REG_RVALID, 1'b1)
    d = REG_RDATA;
  endtask

  task automatic rchk(input logic [5:0] a, input logic [23:0] e);
    logic [23:0] d;
    rd(a, d);
    `CHK(d, e)
  endtask

  // Idle means several quiet edges, so the one-cycle gap between chained sequences is not taken for the end
  task automatic wait_idle();
    int q;
    q = 0;
    for (int i = 0; i < 3000 && q < 4; i++) begin
      @(posedge MCLK);
      q = (SEQ_BUSY === 1'b0) ? q + 1 : 0;
    end
    #1;
    `CHK(SEQ_BUSY, 1'b0)
  endtask

  task automatic stop_test();
    if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    logic [23:0] v, d;
    logic [2:0]  last;
    int          c0, c1;
    repeat (8) @(posedge MCLK);
    RST <= 1'b0;
    // Reset values, unmapped read, random read-back
    rchk(ADDR_CTRL, 24'h000000);
    rchk(ADDR_DELAY, 24'h000000);
    rchk(ADDR_SEL, 24'h000000);
    rchk(6'h3f, 24'h000000);
    for (int i = 0; i < 4; i++) begin
      v = rnd24();
      wr(ADDR_DELAY, v);
      rchk(ADDR_DELAY, v);
      wr(ADDR_SEL, v);
      rchk(ADDR_SEL, v);
    end
    // Level outputs follow their bits
    // Pen detect bit written only while the touch path is off
    wr(ADDR_CTRL, 24'h100101);
    repeat (2) @(posedge MCLK);
    #1;
    `CHK({CONV_POWER_UP, MANUAL_LED, TOUCH_POWER_UP, PEN_DETECT_EN}, 4'hd)
    rchk(ADDR_CTRL, 24'h100101);
    wr(ADDR_CTRL, 24'h001000);
    repeat (2) @(posedge MCLK);
    #1;
    `CHK({CONV_POWER_UP, TOUCH_POWER_UP, PEN_DETECT_EN}, 3'h2)
    wr(ADDR_CTRL, 24'h000002);
    repeat (20) @(posedge MCLK);
    #1;
    `CHK({CONV_POWER_UP, MANUAL_LED, TOUCH_POWER_UP, PEN_DETECT_EN}, 4'h0)
    `CHK(rq.size(), 0)
    // One-shot general sequences with random slots and latency
    wr(ADDR_DELAY, 24'h000000);
    for (int n = 0; n < 4; n++) begin
      v = rnd24();
      last = 3'(rnd24() % 6);
      lat = 4'(1 + rnd24() % 8);
      wr(ADDR_SEL, v);
      rq.delete();
      tq.delete();
      wr(ADDR_CTRL, {17'h0, last, 4'h3});
      wait_idle();
      `CHK(rq.size(), last + 1)
      `CHK((tq[0] - t_wr) / 100 inside {[1:6]}, 1'b1)
      for (int i = 0; i <= last; i++) `CHK(rq[i].channel, v[4*i+:4])
      for (int p = 0; p < 3; p++) begin
        rd(6'(ADDR_RES01 + p), d);
        for (int h = 0; h < 2; h++) if (2 * p + h <= last) `CHK(d[12*h+2+:10], exp_res(v[8*p+4*h+:4]))
      end
      rchk(ADDR_CTRL, {17'h0, last, 4'h1});
    end
    // Pre and inter delays
    lat = 4'h2;
    rq.delete();
    tq.delete();
    wr(ADDR_DELAY, 24'h000021);
    wr(ADDR_CTRL, 24'h000013);
    wait_idle();
    c0 = (tq[0] - t_wr) / 100;
    c1 = (tq[1] - tq[0]) / 100;
    `CHK(c0 inside {[100:106]}, 1'b1)
    `CHK(c1 inside {[200:210]}, 1'b1)
    // Touch start served first, own last slot and actions
    v = rnd24();
    wr(ADDR_TACT, v);
    wr(ADDR_DELAY, 24'h000000);
    rq.delete();
    wr(ADDR_CTRL, 24'h023003);
    wait_idle();
    `CHK(rq.size(), 4)
    for (int i = 0; i < 3; i++) `CHK({rq[i].touch, rq[i].action}, {1'b1, v[TACT_POS+2*i+:2]})
    `CHK(rq[3].touch, 1'b0)
    // Hold blocks a start, release rewriting the start bit lets exactly one run
    for (int k = 0; k < 2; k++) begin
      rq.delete();
      wr(ADDR_CTRL, k ? 24'h00b000 : 24'h00000b);
      repeat (50) @(posedge MCLK);
      `CHK(rq.size(), 0)
      wr(ADDR_CTRL, k ? 24'h003000 : 24'h000003);
      wait_idle();
      `CHK(rq.size(), 1)
    end
    // Continuous runs with post delay, then abort by enable clear
    for (int k = 0; k < 2; k++) begin
      rq.delete();
      tq.delete();
      wr(ADDR_DELAY, k ? 24'h101000 : 24'h000100);
      wr(ADDR_CTRL, k ? 24'h007000 : 24'h000007);
      repeat (450) @(posedge MCLK);
      `CHK(rq.size() inside {[3:5]}, 1'b1)
      `CHK((tq[1] - tq[0]) / 100 inside {[100:110]}, 1'b1)
      if (k) `CHK((tq[0] - t_wr) / 100 inside {[100:106]}, 1'b1)
      `CHK(SEQ_TOUCH, 1'(k))
      wr(ADDR_CTRL, 24'h000000);
      wait_idle();
      rq.delete();
      repeat (300) @(posedge MCLK);
      `CHK(rq.size(), 0)
    end
    stop_test();
  end

  // Watchdog against a hung sequencer
  initial begin
    repeat (60000) @(posedge MCLK);
    n_errors++;
    stop_test();
  end
endmodule
